/* flash_host_ctrl.sv */
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ns
module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter int POLL_LIMIT = 4000
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [21:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic flash_dq_oe,
	input wire logic [15:0] flash_dq_in,
	output logic chip_select_n,
	output logic write_strobe_n,
	output logic output_enable_n,
	output logic hw_reset_n
);
	host_state_t state_reg;
	logic [3:0] op_reg;
	logic [3:0] step_reg;
	logic [21:0] addr_reg;
	logic [15:0] data_reg;
	logic [15:0] out_reg;
	logic [15:0] rdata_reg;
	logic [15:0] last_poll_reg;
	logic [15:0] poll_cnt_reg;
	logic [1:0] wait_reg;
	logic done_reg;
	logic fail_reg;
	logic abort_reg;
	logic hwrst_reg;
	logic [21:0] cyc_addr;
	logic [15:0] cyc_data;
	logic [3:0] cyc_count;
	logic cyc_is_read;
	logic cyc_polls;

	wire logic apb_wr = psel & penable & pwrite;
	wire logic busy = (state_reg != ST_IDLE);
	wire logic start = apb_wr & (paddr == ADDR_CMD) & ~busy;
	wire logic addr_hit = (paddr == ADDR_CMD) | (paddr == ADDR_ADDR) | (paddr == ADDR_DATA) | (paddr == ADDR_STAT) | (paddr == ADDR_RDATA);
	wire logic polling_status_bit = flash_dq_in[7];
	wire logic toggle_status_bit = flash_dq_in[6];
	wire logic exceeded_time_flag = flash_dq_in[5];
	wire logic buffer_abort_flag = flash_dq_in[1];
	wire logic toggled = (toggle_status_bit != last_poll_reg[6]);
	wire logic last_step = (step_reg + 4'h1 == cyc_count);
	wire logic wait_done = (wait_reg == 2'(SETUP_CYC - 1));

	flash_seq_rom u_rom (
		.op(op_reg),
		.step(step_reg),
		.user_addr(addr_reg),
		.user_data(data_reg),
		.cyc_addr(cyc_addr),
		.cyc_data(cyc_data),
		.cyc_count(cyc_count),
		.cyc_is_read(cyc_is_read),
		.cyc_polls(cyc_polls)
	);

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_hit;
	assign flash_dq_oe = (state_reg == ST_SETUP) | (state_reg == ST_STROBE) | (state_reg == ST_HOLD);
	assign flash_dq_out = out_reg;

	// Register reads are combinational on the stored values so APB answers without wait states.
	always_comb
	begin
		prdata = 32'h0000_0000;
		if (paddr == ADDR_ADDR)
			prdata = {10'h000, addr_reg};
		else if (paddr == ADDR_DATA)
			prdata = {16'h0000, data_reg};
		else if (paddr == ADDR_STAT)
			prdata = {27'h0000000, hwrst_reg, abort_reg, fail_reg, done_reg, busy};
		else if (paddr == ADDR_RDATA)
			prdata = {16'h0000, rdata_reg};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			addr_reg <= 22'h000000;
		else if (apb_wr && paddr == ADDR_ADDR && !busy)
			addr_reg <= pwdata[21:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hwrst_reg <= 1'b0;
		else if (start)
			hwrst_reg <= pwdata[4];
	end

	assign hw_reset_n = ~hwrst_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			data_reg <= 16'h0000;
		else if (apb_wr && paddr == ADDR_DATA && !busy)
			data_reg <= pwdata[15:0];
	end

	// The bus word is kept apart from the user word, since the last cycle of a sequence still needs the user word.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			out_reg <= 16'h0000;
		else if (state_reg == ST_NEXT)
			out_reg <= cyc_data;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= ST_IDLE;
			op_reg <= OP_RESET;
			step_reg <= 4'h0;
			flash_addr <= 22'h000000;
			chip_select_n <= 1'b1;
			write_strobe_n <= 1'b1;
			output_enable_n <= 1'b1;
			rdata_reg <= 16'h0000;
			last_poll_reg <= 16'h0000;
			poll_cnt_reg <= 16'h0000;
			wait_reg <= 2'h0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			abort_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					if (start)
					begin
						op_reg <= pwdata[3:0];
						step_reg <= 4'h0;
						done_reg <= 1'b0;
						fail_reg <= 1'b0;
						abort_reg <= 1'b0;
						state_reg <= ST_DONE;
						if (!pwdata[4])
							state_reg <= ST_NEXT;
					end
				end
				ST_NEXT:
				begin
					flash_addr <= cyc_addr;
					wait_reg <= 2'h0;
					chip_select_n <= 1'b0;
					state_reg <= cyc_is_read ? ST_RD_SETUP : ST_SETUP;
				end
				ST_SETUP:
				begin
					// Address settles with the strobe high; the device latches it on its falling edge.
					write_strobe_n <= 1'b0;
					state_reg <= ST_STROBE;
				end
				ST_STROBE:
				begin
					wait_reg <= wait_reg + 2'h1;
					if (wait_done)
					begin
						write_strobe_n <= 1'b1;
						state_reg <= ST_HOLD;
					end
				end
				ST_HOLD:
				begin
					chip_select_n <= 1'b1;
					if (cyc_polls)
					begin
						poll_cnt_reg <= 16'h0000;
						last_poll_reg <= 16'h0000;
						state_reg <= ST_POLL;
					end
					else if (last_step)
						state_reg <= ST_DONE;
					else
					begin
						step_reg <= step_reg + 4'h1;
						state_reg <= ST_NEXT;
					end
				end
				ST_RD_SETUP:
				begin
					output_enable_n <= 1'b0;
					wait_reg <= wait_reg + 2'h1;
					if (wait_done)
						state_reg <= ST_RD_WAIT;
				end
				ST_RD_WAIT:
				begin
					rdata_reg <= flash_dq_in;
					output_enable_n <= 1'b1;
					chip_select_n <= 1'b1;
					state_reg <= ST_DONE;
				end
				ST_POLL:
				begin
					// The toggle bit only moves between separate read cycles, so output enable is pulsed per sample.
					chip_select_n <= 1'b0;
					output_enable_n <= ~output_enable_n;
					flash_addr <= addr_reg;
					if (!output_enable_n)
					begin
						last_poll_reg <= flash_dq_in;
						poll_cnt_reg <= poll_cnt_reg + 16'h0001;
						if (poll_cnt_reg != 16'h0000 && !toggled)
						begin
							rdata_reg <= flash_dq_in;
							fail_reg <= (polling_status_bit != data_reg[7]);
							state_reg <= ST_DONE;
						end
						else if (poll_cnt_reg != 16'h0000 && exceeded_time_flag)
						begin
							fail_reg <= 1'b1;
							state_reg <= ST_DONE;
						end
						else if (poll_cnt_reg != 16'h0000 && buffer_abort_flag)
						begin
							abort_reg <= 1'b1;
							state_reg <= ST_DONE;
						end
						else if (poll_cnt_reg == 16'(POLL_LIMIT))
						begin
							fail_reg <= 1'b1;
							state_reg <= ST_DONE;
						end
					end
				end
				ST_DONE:
				begin
					chip_select_n <= 1'b1;
					output_enable_n <= 1'b1;
					done_reg <= 1'b1;
					state_reg <= ST_IDLE;
				end
				default:
				begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// Every opcode, reads and autoselect included, is refused during a running program by never starting mid-poll.
	AST_ONE_STROBE: assert property (@(posedge pclk) disable iff (!presetn) !write_strobe_n |-> !chip_select_n) else $error("write strobe without chip select");
	AST_NO_WR_READ: assert property (@(posedge pclk) disable iff (!presetn) !(!write_strobe_n && !output_enable_n)) else $error("write and read strobes together");
	AST_STROBE_LEN: assert property (@(posedge pclk) disable iff (!presetn) $fell(write_strobe_n) |-> !write_strobe_n [*2]) else $error("write strobe too short");
	AST_DQ_DRIVEN: assert property (@(posedge pclk) disable iff (!presetn) !write_strobe_n |-> flash_dq_oe) else $error("data not driven during strobe");
	AST_ADDR_STABLE: assert property (@(posedge pclk) disable iff (!presetn) !write_strobe_n && $past(!write_strobe_n) |-> $stable(flash_addr)) else $error("address moved in strobe");
	AST_DONE_IDLE: assert property (@(posedge pclk) disable iff (!presetn) state_reg == ST_DONE |=> state_reg == ST_IDLE && done_reg) else $error("done not flagged");
	AST_POLL_NO_WR: assert property (@(posedge pclk) disable iff (!presetn) state_reg == ST_POLL |-> write_strobe_n && !flash_dq_oe) else $error("write during program");
	AST_RESET_DATA: assert property (@(posedge pclk) disable iff (!presetn) state_reg == ST_SETUP && op_reg == OP_RESET |-> out_reg == CMD_RESET) else $error("bad reset data");
	COV_PROG: cover property (@(posedge pclk) disable iff (!presetn) state_reg == ST_POLL ##1 state_reg == ST_DONE);
	COV_READ: cover property (@(posedge pclk) disable iff (!presetn) state_reg == ST_RD_WAIT);
	COV_FAIL: cover property (@(posedge pclk) disable iff (!presetn) $rose(fail_reg));
endmodule : flash_host_ctrl

/* flash_host_pkg.sv */
package flash_host_pkg;
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_ADDR = 8'h04;
	localparam logic [7:0] ADDR_DATA = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0c;
	localparam logic [7:0] ADDR_RDATA = 8'h10;
	localparam logic [3:0] OP_RESET = 4'h0;
	localparam logic [3:0] OP_PROGRAM = 4'h1;
	localparam logic [3:0] OP_AUTOSEL = 4'h2;
	localparam logic [3:0] OP_READ = 4'h3;
	localparam logic [3:0] OP_BYP_ENTER = 4'h4;
	localparam logic [3:0] OP_BYP_PROG = 4'h5;
	localparam logic [3:0] OP_BYP_EXIT = 4'h6;
	localparam logic [3:0] OP_SEC_ENTER = 4'h7;
	localparam logic [3:0] OP_SEC_EXIT = 4'h8;
	localparam logic [3:0] OP_ABORT_RST = 4'h9;
	localparam logic [15:0] CMD_RESET = 16'h00f0;
	localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
	localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
	localparam logic [15:0] CMD_BYPASS = 16'h0020;
	localparam logic [15:0] CMD_BYP_EXIT1 = 16'h0090;
	localparam logic [15:0] CMD_BYP_EXIT2 = 16'h0000;
	localparam logic [15:0] CMD_SEC_ENTER = 16'h0088;
	localparam logic [15:0] CMD_SEC_EXIT = 16'h0090;
	localparam logic [15:0] CMD_EXIT_FINAL = 16'h0000;
	localparam logic [15:0] UNLOCK1_DATA = 16'h00aa;
	localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
	localparam logic [21:0] UNLOCK1_ADDR = 22'h000555;
	localparam logic [21:0] UNLOCK2_ADDR = 22'h0002aa;
	localparam logic [7:0] ID_MAKER = 8'h00;
	localparam logic [7:0] ID_DEV1 = 8'h01;
	localparam logic [7:0] ID_DEV2 = 8'h0e;
	localparam logic [7:0] ID_DEV3 = 8'h0f;
	localparam logic [7:0] ID_FACT_LOCK = 8'h03;
	localparam logic [7:0] ID_SECT_PROT = 8'h02;
	localparam int SERIAL_WORDS = 8;
	localparam int T_SETUP_NS = 40;
	localparam int CLK_NS = 20;
	localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] SEQ_MAX = 4'h6;
	typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_NEXT, ST_RD_SETUP, ST_RD_WAIT, ST_POLL, ST_DONE} host_state_t;
endpackage : flash_host_pkg

/* flash_seq_rom.sv */
`timescale 1ns/1ns
module flash_seq_rom
	import flash_host_pkg::*;
(
	input wire logic [3:0] op,
	input wire logic [3:0] step,
	input wire logic [21:0] user_addr,
	input wire logic [15:0] user_data,
	output logic [21:0] cyc_addr,
	output logic [15:0] cyc_data,
	output logic [3:0] cyc_count,
	output logic cyc_is_read,
	output logic cyc_polls
);
	wire logic unl1 = (step == 4'h0);
	wire logic unl2 = (step == 4'h1);
	wire logic [21:0] unl_addr = unl1 ? UNLOCK1_ADDR : UNLOCK2_ADDR;
	wire logic [15:0] unl_data = unl1 ? UNLOCK1_DATA : UNLOCK2_DATA;
	wire logic in_unlock = unl1 | unl2;
	always_comb
	begin
		cyc_addr = user_addr;
		cyc_data = user_data;
		cyc_count = 4'h1;
		cyc_is_read = 1'b0;
		cyc_polls = 1'b0;
		case (op)
			OP_RESET:
			begin
				cyc_data = CMD_RESET;
			end
			OP_PROGRAM:
			begin
				cyc_count = 4'h4;
				cyc_addr = in_unlock ? unl_addr : (step == 4'h2 ? UNLOCK1_ADDR : user_addr);
				cyc_data = in_unlock ? unl_data : (step == 4'h2 ? CMD_PROGRAM : user_data);
				cyc_polls = (step == 4'h3);
			end
			OP_AUTOSEL, OP_BYP_ENTER, OP_SEC_ENTER:
			begin
				cyc_count = 4'h3;
				cyc_addr = in_unlock ? unl_addr : UNLOCK1_ADDR;
				cyc_data = in_unlock ? unl_data : (op == OP_AUTOSEL ? CMD_AUTOSEL : (op == OP_BYP_ENTER ? CMD_BYPASS : CMD_SEC_ENTER));
			end
			OP_READ:
			begin
				cyc_is_read = 1'b1;
			end
			OP_BYP_PROG:
			begin
				cyc_count = 4'h2;
				cyc_data = unl1 ? CMD_PROGRAM : user_data;
				cyc_polls = unl2;
			end
			OP_BYP_EXIT:
			begin
				cyc_count = 4'h2;
				cyc_data = unl1 ? CMD_BYP_EXIT1 : CMD_BYP_EXIT2;
			end
			OP_SEC_EXIT:
			begin
				cyc_count = 4'h4;
				cyc_addr = in_unlock ? unl_addr : UNLOCK1_ADDR;
				cyc_data = in_unlock ? unl_data : (step == 4'h2 ? CMD_SEC_EXIT : CMD_EXIT_FINAL);
			end
			OP_ABORT_RST:
			begin
				cyc_count = 4'h3;
				cyc_addr = in_unlock ? unl_addr : UNLOCK1_ADDR;
				cyc_data = in_unlock ? unl_data : CMD_RESET;
			end
			default:
			begin
				cyc_data = CMD_RESET;
			end
		endcase
	end
endmodule : flash_seq_rom

/* flash_dev_model.sv */
`timescale 1ns/1ns
module flash_dev_model
	import flash_host_pkg::*;
#(
	parameter logic [7:0] ID_BASE = 8'h5a,
	parameter int BUSY_READS = 3
)
(
	input wire logic [21:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic flash_dq_oe,
	output logic [15:0] flash_dq_in,
	input wire logic chip_select_n,
	input wire logic write_strobe_n,
	input wire logic output_enable_n,
	input wire logic hw_reset_n
);
	// ID_BASE and the serial word pattern are arbitrary values.
	typedef enum logic [1:0] {M_READ, M_AUTO, M_BYP, M_SEC} mode_t;
	mode_t mode;
	logic [15:0] mem [16];
	logic [15:0] pdata, rd_val, last_val;
	logic [21:0] la;
	logic [1:0] cyc;
	logic armed, exitp, tgl, fail;
	int busy, wr_count;
	wire wsn = chip_select_n | write_strobe_n;
	wire rd_en = !chip_select_n && !output_enable_n && !flash_dq_oe;
	task automatic clear;
		{armed, exitp, fail, cyc} = 5'h00;
		busy = 0;
		mode = M_READ;
	endtask : clear
	task automatic wr(input logic [15:0] d);
		logic [7:0] c;
		logic a0, x0;
		c = d[7:0];
		wr_count++;
		if (busy > 0 && !(fail && c == CMD_RESET[7:0])) return;
		a0 = armed;
		x0 = exitp;
		{armed, exitp} = 2'b00;
		if (a0)
		begin
			fail = |(d & ~mem[la[3:0]]);
			mem[la[3:0]] = mem[la[3:0]] & d;
			pdata = d;
			busy = BUSY_READS;
		end
		else if (x0 && c == CMD_EXIT_FINAL[7:0]) mode = M_READ;
		else if (mode == M_BYP)
		begin
			armed = (c == CMD_PROGRAM[7:0]);
			exitp = (c == CMD_BYP_EXIT1[7:0]);
		end
		else if (c == CMD_RESET[7:0]) clear();
		else if (cyc == 2'd0) cyc = (c == UNLOCK1_DATA[7:0] && la[10:0] == UNLOCK1_ADDR[10:0]) ? 2'd1 : 2'd0;
		else if (cyc == 2'd1) cyc = (c == UNLOCK2_DATA[7:0] && la[10:0] == UNLOCK2_ADDR[10:0]) ? 2'd2 : 2'd0;
		else
		begin
			cyc = 2'd0;
			armed = (c == CMD_PROGRAM[7:0]);
			exitp = (c == CMD_SEC_EXIT[7:0] && mode == M_SEC);
			if (c == CMD_BYPASS[7:0]) mode = M_BYP;
			if (c == CMD_SEC_ENTER[7:0]) mode = M_SEC;
			if (c == CMD_AUTOSEL[7:0] && mode != M_SEC) mode = M_AUTO;
		end
	endtask : wr
	initial
	begin
		foreach (mem[i]) mem[i] = 16'hffff;
		wr_count = 0;
		{tgl, last_val} = 17'h00000;
		clear();
	end
	always @(negedge hw_reset_n) clear();
	always @(negedge wsn) la = flash_addr;
	always @(posedge wsn) if (hw_reset_n === 1'b1 && la !== 'x) wr(flash_dq_out);
	always_comb
		if (busy > 0) rd_val = {8'h00, ~pdata[7], tgl, fail, 5'h00};
		else if (mode == M_AUTO) rd_val = {ID_BASE, flash_addr[7:0]};
		else if (mode == M_SEC) rd_val = {13'h1e3c, flash_addr[2:0]};
		else rd_val = mem[flash_addr[3:0]];
	always @(negedge rd_en)
	begin
		last_val = rd_val;
		tgl = ~tgl;
		if (busy > 0 && !fail) busy--;
	end
	// A released bus shows the inverse of the last word, so a late sample cannot pass by luck.
	assign flash_dq_in = rd_en ? rd_val : ~last_val;
endmodule : flash_dev_model

/* tb_top.sv */
`timescale 1ns/1ns
module tb_top;
	import flash_host_pkg::*;
	localparam logic [7:0] ID_B = 8'h5a;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, err, flash_dq_oe, chip_select_n, write_strobe_n, output_enable_n, hw_reset_n;
	logic [21:0] flash_addr;
	logic [15:0] flash_dq_out, flash_dq_in;
	int num_errors = 0, cmp_count = 0, cycles = 0;
	always #10 pclk = ~pclk;
	flash_host_ctrl #(.POLL_LIMIT(20)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .chip_select_n, .write_strobe_n,
		.output_enable_n, .hw_reset_n);
	flash_dev_model #(.ID_BASE(ID_B)) dev (.flash_addr, .flash_dq_out, .flash_dq_oe, .flash_dq_in, .chip_select_n,
		.write_strobe_n, .output_enable_n, .hw_reset_n);
	task automatic give_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// A negative count skips the cycle check, for operations that end in a device fault.
	task automatic op(input logic [3:0] code, input logic [21:0] a, input logic [15:0] d, input int nw);
		int w0;
		w0 = dev.wr_count;
		apb(1'b1, ADDR_ADDR, {10'h000, a});
		apb(1'b1, ADDR_DATA, {16'h0000, d});
		apb(1'b1, ADDR_CMD, {28'h0000000, code});
		rd = 32'h00000001;
		while (rd[0] !== 1'b0 || rd[3:1] === 3'b000) apb(1'b0, ADDR_STAT, 32'h00000000);
		if (nw >= 0) check("flash write cycles", nw, dev.wr_count - w0);
	endtask : op
	task automatic rdw(input logic [21:0] a, input logic [15:0] exp);
		op(OP_READ, a, 16'h0000, 0);
		apb(1'b0, ADDR_RDATA, 32'h00000000);
		check("read word", {16'h0000, exp}, {16'h0000, rd[15:0]});
	endtask : rdw
	task automatic t_program;
		apb(1'b0, 8'h20, 32'h00000000);
		check("unmapped error", 1'b1, err);
		rdw(22'h000003, 16'hffff);
		op(OP_PROGRAM, 22'h000005, 16'h1234, 4);
		check("program status", 2'b01, rd[2:1]);
		apb(1'b0, ADDR_DATA, 32'h00000000);
		check("data register", 32'h00001234, rd);
		apb(1'b0, ADDR_ADDR, 32'h00000000);
		check("address register", 32'h00000005, rd);
		apb(1'b0, ADDR_RDATA, 32'h00000000);
		check("final poll word", 32'h00001234, rd);
		rdw(22'h000005, 16'h1234);
		op(OP_PROGRAM, 22'h000005, 16'hffff, -1);
		check("set zero bit fails", 1'b1, rd[2]);
		op(OP_RESET, 22'h3fffff, 16'h0000, 1);
		rdw(22'h000005, 16'h1234);
		$display("test program done");
	endtask : t_program
	task automatic t_autosel;
		logic [7:0] ids [6];
		ids = '{ID_MAKER, ID_DEV1, ID_DEV2, ID_DEV3, ID_FACT_LOCK, ID_DEV1};
		op(OP_AUTOSEL, 22'h000000, 16'h0000, 3);
		foreach (ids[i]) rdw({14'h0000, ids[i]}, {ID_B, ids[i]});
		rdw({14'h0020, ID_SECT_PROT}, {ID_B, ID_SECT_PROT});
		op(OP_RESET, 22'h000000, 16'h0000, 1);
		rdw(22'h000005, 16'h1234);
		$display("test autoselect done");
	endtask : t_autosel
	task automatic t_bypass;
		op(OP_BYP_ENTER, 22'h000000, 16'h0000, 3);
		op(OP_BYP_PROG, 22'h000006, 16'h00f0, 2);
		op(OP_BYP_PROG, 22'h000007, 16'h0f0f, 2);
		op(OP_BYP_EXIT, 22'h000000, 16'h0000, 2);
		rdw(22'h000006, 16'h00f0);
		rdw(22'h000007, 16'h0f0f);
		$display("test bypass done");
	endtask : t_bypass
	task automatic t_secured;
		op(OP_SEC_ENTER, 22'h000000, 16'h0000, 3);
		rdw(22'h00000a, {13'h1e3c, 3'd2});
		op(OP_SEC_EXIT, 22'h000000, 16'h0000, 4);
		rdw(22'h00000a, 16'hffff);
		$display("test secured done");
	endtask : t_secured
	task automatic t_hwrst;
		apb(1'b1, ADDR_CMD, 32'h00000010);
		apb(1'b0, ADDR_STAT, 32'h00000000);
		check("hardware reset held", 2'b10, {rd[4], hw_reset_n});
		op(OP_RESET, 22'h000000, 16'h0000, 1);
		check("hardware reset released", 1'b1, hw_reset_n);
		op(OP_ABORT_RST, 22'h000000, 16'h0000, 3);
		check("abort reset status", 2'b01, rd[2:1]);
		rdw(22'h000005, 16'h1234);
		$display("test hardware reset done");
	endtask : t_hwrst
	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_program();
		t_autosel();
		t_bypass();
		t_secured();
		t_hwrst();
		give_verdict();
	end
endmodule : tb_top
